/* hdl/rtm_timer.sv */
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
module rtm_timer
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_first_timer_input_pin,
  input wire logic i_port_b_pin_zero,
  input wire logic i_port_b_pin_one,
  input wire logic i_port_b_pin_two,
  input wire logic i_comparator_out,
  output logic o_timer_out,
  output logic o_timer_irq
);
  localparam logic [11:0] RTM_OFF_CTRL = 12'h000;
  localparam logic [11:0] RTM_OFF_COUNT = 12'h004;
  localparam logic [11:0] RTM_OFF_RELOAD = 12'h008;
  localparam logic [11:0] RTM_OFF_STATUS = 12'h00c;
  localparam int RTM_B_EN = 0;
  localparam int RTM_B_MODE = 1;
  localparam int RTM_B_PRE = 4;
  localparam int RTM_B_POL = 7;
  localparam int RTM_B_OEN = 8;
  localparam int RTM_B_ALT = 9;

  typedef struct packed {
    rtm_ctrl_t ctrl;
    rtm_state_t state;
    logic [15:0] count;
    logic [15:0] reload;
    logic out;
    logic out_pin;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtm_top_t;
  rtm_top_t st_r;
  rtm_top_t st_nxt;

  logic pin_rise;
  logic pin_fall;
  logic pa_rise;
  logic pa_fall;
  logic pb_rise;
  logic pb_fall;
  logic pc_rise;
  logic pc_fall;
  logic cmp_rise;
  logic cmp_fall;
  logic pre_tick;
  logic pre_run;
  logic in_rise;
  logic in_fall;
  logic in_edge;
  logic cmp_edge;
  logic step;
  logic at_reload;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;

  rtm_sync_edge u_sync_pin (
    .i_clk(i_clk), .i_reset(i_reset), .i_async(i_first_timer_input_pin),
    .o_level(), .o_rise(pin_rise), .o_fall(pin_fall)
  );
  rtm_sync_edge u_sync_a (
    .i_clk(i_clk), .i_reset(i_reset), .i_async(i_port_b_pin_zero),
    .o_level(), .o_rise(pa_rise), .o_fall(pa_fall)
  );
  rtm_sync_edge u_sync_b (
    .i_clk(i_clk), .i_reset(i_reset), .i_async(i_port_b_pin_one),
    .o_level(), .o_rise(pb_rise), .o_fall(pb_fall)
  );
  rtm_sync_edge u_sync_c (
    .i_clk(i_clk), .i_reset(i_reset), .i_async(i_port_b_pin_two),
    .o_level(), .o_rise(pc_rise), .o_fall(pc_fall)
  );
  rtm_sync_edge u_sync_cmp (
    .i_clk(i_clk), .i_reset(i_reset), .i_async(i_comparator_out),
    .o_level(), .o_rise(cmp_rise), .o_fall(cmp_fall)
  );

  // Prescaler runs only in clock-driven modes while counting
  assign pre_run = st_r.ctrl.enable && (st_r.state == RTM_ST_RUN) &&
                   (st_r.ctrl.mode != RTM_MODE_COUNTER) &&
                   (st_r.ctrl.mode != RTM_MODE_CMP);

  rtm_prescaler u_pre (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_run(pre_run),
    .i_prescale(st_r.ctrl.prescale),
    .o_tick(pre_tick)
  );

  // Any enabled alternate pin counts as the timer input
  assign in_rise = pin_rise | (st_r.ctrl.alt_en[0] & pa_rise) |
                   (st_r.ctrl.alt_en[1] & pb_rise) |
                   (st_r.ctrl.alt_en[2] & pc_rise);
  assign in_fall = pin_fall | (st_r.ctrl.alt_en[0] & pa_fall) |
                   (st_r.ctrl.alt_en[1] & pb_fall) |
                   (st_r.ctrl.alt_en[2] & pc_fall);
  assign in_edge = st_r.ctrl.polarity ? in_fall : in_rise;
  assign cmp_edge = st_r.ctrl.polarity ? cmp_fall : cmp_rise;

  always_comb begin
    unique case (st_r.ctrl.mode)
      RTM_MODE_COUNTER: step = in_edge;
      RTM_MODE_CMP: step = cmp_edge;
      default: step = pre_tick;
    endcase
  end

  // Reload 0000h is only reached after the FFFFh wrap: full range
  assign at_reload = (st_r.count == st_r.reload);

  assign apb_acc = i_psel & i_penable & ~st_r.pready;
  assign apb_wr = apb_acc & i_pwrite;
  assign apb_rd = apb_acc & ~i_pwrite;

  always_comb begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    st_nxt.pready = apb_acc;
    st_nxt.pslverr = 1'b0;

    // Timer engine
    if (!st_r.ctrl.enable) begin
      st_nxt.state = RTM_ST_IDLE;
      st_nxt.out = st_r.ctrl.polarity;
    end else begin
      unique case (st_r.state)
        RTM_ST_IDLE: begin
          if (st_r.ctrl.mode == RTM_MODE_TRIG) begin
            st_nxt.state = RTM_ST_ARMED;
          end else begin
            st_nxt.state = RTM_ST_RUN;
          end
        end
        RTM_ST_ARMED: begin
          st_nxt.out = st_r.ctrl.polarity;
          if (in_edge) begin
            st_nxt.state = RTM_ST_RUN;
          end
        end
        RTM_ST_RUN: begin
          // Output holds while counting so a polarity flip lands at time-out
          if (step) begin
            if (at_reload) begin
              st_nxt.count = RTM_CNT_RST;
              st_nxt.irq = 1'b1;
              unique case (st_r.ctrl.mode)
                RTM_MODE_ONESHOT: begin
                  st_nxt.out = ~st_r.out;
                  st_nxt.ctrl.enable = 1'b0;
                  st_nxt.state = RTM_ST_IDLE;
                end
                RTM_MODE_TRIG: begin
                  st_nxt.out = ~st_r.ctrl.polarity;
                  st_nxt.state = RTM_ST_ARMED;
                end
                default: begin
                  st_nxt.out = ~st_r.out;
                end
              endcase
            end else if (st_r.count == 16'hffff) begin
              st_nxt.count = RTM_CNT_WRAP;
            end else begin
              st_nxt.count = 16'(st_r.count + 16'h0001);
            end
          end
        end
        default: st_nxt.state = RTM_ST_IDLE;
      endcase
    end

    // Register writes come last: a software write beats the self-disable
    if (apb_wr) begin
      unique case (i_paddr)
        RTM_OFF_CTRL: begin
          st_nxt.ctrl.enable = i_pwdata[RTM_B_EN];
          st_nxt.ctrl.mode = rtm_mode_t'(i_pwdata[RTM_B_MODE +: 3]);
          st_nxt.ctrl.prescale = i_pwdata[RTM_B_PRE +: RTM_PRE_W];
          st_nxt.ctrl.polarity = i_pwdata[RTM_B_POL];
          st_nxt.ctrl.out_en = i_pwdata[RTM_B_OEN];
          st_nxt.ctrl.alt_en = i_pwdata[RTM_B_ALT +: RTM_ALT_N];
        end
        RTM_OFF_COUNT: st_nxt.count = i_pwdata[15:0];
        RTM_OFF_RELOAD: st_nxt.reload = i_pwdata[15:0];
        RTM_OFF_STATUS: ;
        default: st_nxt.pslverr = 1'b1;
      endcase
    end

    // Pin level is registered after gating by the output enable
    st_nxt.out_pin = st_nxt.out & st_nxt.ctrl.out_en;

    st_nxt.prdata = 32'h0000_0000;
    if (apb_rd) begin
      unique case (i_paddr)
        RTM_OFF_CTRL: begin
          st_nxt.prdata[RTM_B_EN] = st_r.ctrl.enable;
          st_nxt.prdata[RTM_B_MODE +: 3] = st_r.ctrl.mode;
          st_nxt.prdata[RTM_B_PRE +: RTM_PRE_W] = st_r.ctrl.prescale;
          st_nxt.prdata[RTM_B_POL] = st_r.ctrl.polarity;
          st_nxt.prdata[RTM_B_OEN] = st_r.ctrl.out_en;
          st_nxt.prdata[RTM_B_ALT +: RTM_ALT_N] = st_r.ctrl.alt_en;
        end
        RTM_OFF_COUNT: st_nxt.prdata[15:0] = st_r.count;
        RTM_OFF_RELOAD: st_nxt.prdata[15:0] = st_r.reload;
        RTM_OFF_STATUS: begin
          st_nxt.prdata[2:0] = st_r.state;
          st_nxt.prdata[3] = st_r.out;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= '0;
      st_r.state <= RTM_ST_IDLE;
      st_r.count <= RTM_CNT_START;
      st_r.reload <= RTM_RELOAD_RST;
      st_r.ctrl.mode <= RTM_MODE_ONESHOT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_prdata = st_r.prdata;
  assign o_pready = st_r.pready;
  assign o_pslverr = st_r.pslverr;
  assign o_timer_irq = st_r.irq;
  assign o_timer_out = st_r.out_pin;
endmodule

/* hdl/rtm_pkg.sv */
package rtm_pkg;
  localparam int RTM_CNT_W = 16;
  localparam int RTM_PRE_W = 3;
  localparam int RTM_ALT_N = 3;
  localparam int RTM_PDIV_W = 7;
  localparam logic [15:0] RTM_CNT_START = 16'h0001;
  localparam logic [15:0] RTM_CNT_WRAP = 16'h0000;
  localparam logic [15:0] RTM_CNT_RST = 16'h0001;
  localparam logic [15:0] RTM_RELOAD_RST = 16'h0000;
  localparam logic [6:0] RTM_PDIV_ZERO = 7'h00;

  typedef enum logic [2:0] {
    RTM_MODE_ONESHOT = 3'h0,
    RTM_MODE_CONT = 3'h1,
    RTM_MODE_COUNTER = 3'h2,
    RTM_MODE_TRIG = 3'h3,
    RTM_MODE_CMP = 3'h4
  } rtm_mode_t;

  typedef enum logic [2:0] {
    RTM_ST_IDLE = 3'b001,
    RTM_ST_ARMED = 3'b010,
    RTM_ST_RUN = 3'b100
  } rtm_state_t;

  typedef struct packed {
    logic enable;
    rtm_mode_t mode;
    logic [2:0] prescale;
    logic polarity;
    logic out_en;
    logic [2:0] alt_en;
  } rtm_ctrl_t;

  typedef struct packed {
    logic load;
    logic [15:0] value;
  } rtm_wr_t;
endpackage

/* hdl/rtm_sync_edge.sv */
`timescale 1ns/1ns
module rtm_sync_edge
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } rtm_se_t;
  rtm_se_t st_r;
  rtm_se_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edges come only from the second and third stages
  assign o_level = st_r.s2;
  assign o_rise = st_r.s2 & ~st_r.s3;
  assign o_fall = ~st_r.s2 & st_r.s3;
endmodule

/* hdl/rtm_prescaler.sv */
`timescale 1ns/1ns
module rtm_prescaler
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [2:0] i_prescale,
  output logic o_tick
);
  typedef struct packed {
    logic [6:0] div;
  } rtm_ps_t;
  rtm_ps_t st_r;
  rtm_ps_t st_nxt;
  logic [6:0] last;

  always_comb begin
    last = 7'((8'h01 << i_prescale) - 8'h01);
    st_nxt = st_r;
    o_tick = 1'b0;
    if (!i_run) begin
      st_nxt.div = RTM_PDIV_ZERO;
    end else if (st_r.div >= last) begin
      st_nxt.div = RTM_PDIV_ZERO;
      o_tick = 1'b1;
    end else begin
      st_nxt.div = 7'(st_r.div + 7'h01);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* tb/rtm_timer_sva.sv */
`timescale 1ns/1ns
module rtm_timer_chk
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_timer_out,
  input wire logic o_timer_irq
);
  logic wr_ctrl;
  logic [2:0] en_h;
  logic [2:0] oe_h;
  logic [2:0] pol_h;
  assign wr_ctrl = i_psel && i_penable && !o_pready && i_pwrite &&
    i_paddr == 12'h000;
  // Last written control bits with two cycles of history
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      en_h <= 3'h0;
      oe_h <= 3'h0;
      pol_h <= 3'h0;
    end else begin
      en_h <= {en_h[1:0], wr_ctrl ? i_pwdata[0] : en_h[0]};
      oe_h <= {oe_h[1:0], wr_ctrl ? i_pwdata[8] : oe_h[0]};
      pol_h <= {pol_h[1:0], wr_ctrl ? i_pwdata[7] : pol_h[0]};
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  chk_one_wait: assert property (i_psel && i_penable && !o_pready |=>
    o_pready) else $error("ready not one cycle after access");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  chk_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  chk_bad_addr: assert property (o_pready && $past(i_paddr) >= 12'h010
    |-> o_pslverr) else $error("unmapped access not refused");
  chk_good_read: assert property (o_pready && !$past(i_pwrite) &&
    $past(i_paddr) < 12'h010 && $past(i_paddr[1:0]) == 2'h0 |->
    !o_pslverr) else $error("mapped refused");
  chk_bad_zero: assert property (o_pslverr && !$past(i_pwrite) |->
    o_prdata == 32'h0) else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($fell(i_reset) |-> !o_timer_irq &&
    !o_timer_out && !o_pready) else $error("outputs busy after reset");
  chk_off_no_irq: assert property (en_h == 3'h0 |-> !o_timer_irq)
    else $error("interrupt while disabled");
  chk_out_gated: assert property (oe_h == 3'h0 |-> !o_timer_out)
    else $error("output driven while not enabled");
  chk_idle_level: assert property (en_h == 3'h0 && oe_h == 3'h7 &&
    (pol_h == 3'h0 || pol_h == 3'h7) |-> o_timer_out == pol_h[0])
    else $error("idle output not at polarity level");
  cov_irq: cover property (o_timer_irq);
  cov_err: cover property (o_pslverr);
  cov_out: cover property ($rose(o_timer_out));
endmodule

bind rtm_timer rtm_timer_chk i_chk (.*);

/* tb/rtm_pins.sv */
`timescale 1ns/1ns
module rtm_pins
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [2:0] i_src,
  output logic [4:0] o_lines
);
  logic [2:0] ph;
  initial begin
    ph = 3'h0;
    o_lines = 5'h0;
  end
  // One pulse: high four cycles, low at least four, pulled low when idle
  always @(posedge i_clk) begin
    if (i_go && ph == 3'h0) ph <= 3'h1;
    else if (ph != 3'h0) ph <= ph + 3'h1;
    o_lines <= (ph >= 3'h1 && ph <= 3'h4) ? 5'h01 << i_src : 5'h00;
  end
endmodule

/* tb/rtm_timer_test.sv */
`timescale 1ns/1ns
module rtm_timer_test
  import rtm_pkg::*;
;
  logic i_clk, i_reset, psel, pen, pwr, go, ready, bad, tout, irq, er;
  logic [11:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [4:0] lines;
  logic [2:0] src;
  logic [31:0] cw;
  int err_total, total_checks, irqs, t0, t1;
  rtm_timer i_dut(.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata),
    .o_prdata(rdata), .o_pready(ready), .o_pslverr(bad),
    .i_first_timer_input_pin(lines[0]), .i_port_b_pin_zero(lines[1]),
    .i_port_b_pin_one(lines[2]), .i_port_b_pin_two(lines[3]),
    .i_comparator_out(lines[4]), .o_timer_out(tout), .o_timer_irq(irq));
  rtm_pins i_pins(.i_clk(i_clk), .i_go(go), .i_src(src), .o_lines(lines));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (irq === 1'b1) irqs <= irqs + 1;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (ready !== 1'b1);
    rd = rdata;
    er = bad;
    check(n, 2);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic setup(input logic [31:0] c, input logic [15:0] s,
                       input logic [15:0] r);
    apb(1'b1, 12'h000, c & 32'hfffffffe);
    apb(1'b1, 12'h004, {16'h0, s});
    apb(1'b1, 12'h008, {16'h0, r});
    irqs = 0;
    apb(1'b1, 12'h000, c);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (irq !== 1'b1);
  endtask
  task automatic pulse(input logic [2:0] s);
    src <= s;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (9) @(posedge i_clk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    close_out;
  end
  initial begin
    {i_reset, psel, pen, pwr, go, addr, wdata, src} = '1;
    {psel, pen, pwr, go, addr, wdata, src} = '0;
    {err_total, total_checks, irqs} = '0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check(rd, 32'h0);
    check(er, 1'b1);
    apb(1'b1, 12'h00c, 32'hf);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd[2:0], 3'h1);
    // Start-count and wrap differences cancel the fixed start latency
    setup(32'h3, 16'h0000, 16'h2);
    wait_irq(t0);
    setup(32'h3, 16'hfffe, 16'h2);
    wait_irq(t1);
    check(t1 - t0, 2);
    setup(32'h3, 16'hfffe, 16'h0);
    wait_irq(t1);
    check(t1 - t0, 0);
    setup(32'h3, 16'h1, 16'h5);
    wait_irq(t0);
    wait_irq(t1);
    check(t1, 5);
    setup(32'h3, 16'h3, 16'h5);
    wait_irq(t1);
    check(t0 - t1, 2);
    for (int p = 0; p < 8; p += 7) begin
      setup(32'h3 | p << 4, 16'h1, 16'h3);
      wait_irq(t0);
      wait_irq(t1);
      check(t1, 3 << p);
    end
    setup(32'h3, 16'h1, 16'h1);
    wait_irq(t0);
    wait_irq(t1);
    check(t1, 1);
    setup(32'h101, 16'h1, 16'h3);
    wait_irq(t0);
    check(tout, 1'b1);
    repeat (2) @(posedge i_clk);
    check(tout, 1'b0);
    repeat (50) @(posedge i_clk);
    check(irqs, 1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd[0], 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h1);
    setup(32'h101, 16'h1, 16'h8);
    apb(1'b1, 12'h000, 32'h181);
    check(tout, 1'b0);
    wait_irq(t0);
    repeat (2) @(posedge i_clk);
    check(tout, 1'b1);
    setup(32'hf7, 16'h1, 16'h4);
    repeat (40) @(posedge i_clk);
    check(irqs, 0);
    repeat (3) pulse(3'h0);
    repeat (700) @(posedge i_clk);
    check(irqs, 1);
    pulse(3'h0);
    repeat (700) @(posedge i_clk);
    check(irqs, 2);
    for (int s = 0; s < 5; s++) begin
      cw = (s == 4 ? 32'h9 : 32'h5) | 32'h170 | (s % 2) << 7;
      if (s > 0 && s < 4) cw = cw | 32'h100 << s;
      setup(cw, 16'h1, 16'h3);
      check(tout, cw[7]);
      repeat (9) pulse(s[2:0]);
      @(posedge i_clk);
      check(irqs, 3);
      check(tout, !cw[7]);
    end
    close_out;
  end
endmodule
